// ---- hdl/sdac_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module sdac_fifo
    import sdac_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } sdac_fptr_t;

    sdac_fptr_t ptr_r;
    sdac_fptr_t ptr_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;

    assign empty = ptr_r.wr == ptr_r.rd;
    assign full = (ptr_r.wr[AW] != ptr_r.rd[AW])
        && (ptr_r.wr[AW-1:0] == ptr_r.rd[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[ptr_r.rd[AW-1:0]];

    always_comb begin
        ptr_nxt = ptr_r;
        if (in_valid && !full) begin
            ptr_nxt.wr = ptr_r.wr + 1'b1;
        end
        if (out_ready && !empty) begin
            ptr_nxt.rd = ptr_r.rd + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ptr_r <= '0;
        end else begin
            ptr_r <= ptr_nxt;
        end
        if (in_valid && !full) begin
            mem[ptr_r.wr[AW-1:0]] <= in_data;
        end
    end

    fifo_no_overfill_a: assert property (@(posedge clk) disable iff (reset)
        full |=> $stable(ptr_r.wr))
        else $error("fifo write pointer moved while full");

endmodule : sdac_fifo
`default_nettype wire

// ---- hdl/sdac_pkg.sv ----
package sdac_pkg;

    typedef enum logic [1:0] {
        SDAC_IDLE = 2'h0,
        SDAC_RUN = 2'h1,
        SDAC_DUMP = 2'h3
    } sdac_state_t;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] irq_en;
        logic [15:0] result;
        logic [3:0] conv_ctrl;
        logic [1:0] chop;
        logic [7:0] net_a;
        logic [5:0] net_b;
        logic [4:0] net_c;
        logic [3:0] net_d;
        logic [7:0] rd_data;
        logic [12:0] rate_cnt;
        logic [15:0] accum;
        sdac_state_t state;
    } sdac_ctl_t;

endpackage : sdac_pkg

// ---- hdl/sdac_regs.svh ----
`ifndef SDAC_REGS_SVH
`define SDAC_REGS_SVH

`define SDAC_ADDR_IRQ_FLAGS 8'h06
`define SDAC_ADDR_IRQ_EN 8'h07
`define SDAC_ADDR_RES_HI 8'h10
`define SDAC_ADDR_RES_LO 8'h11
`define SDAC_ADDR_CONV_CTRL 8'h13
`define SDAC_ADDR_CHOP_CTRL 8'h15
`define SDAC_ADDR_NET_A 8'h18
`define SDAC_ADDR_NET_B 8'h19
`define SDAC_ADDR_NET_C 8'h1A
`define SDAC_ADDR_NET_D 8'h1B
`define SDAC_ADDR_SAMPLE 8'h1C

`define SDAC_RST_BYTE 8'h00
`define SDAC_RST_WORD 16'h0000
`define SDAC_IRQ_BIT 2
`define SDAC_GIE_BIT 7
`define SDAC_COMB_BIT 3
`define SDAC_CHOP_LSB 2
`define SDAC_ONF_BIT 1
`define SDAC_SHORT_BIT 0
`define SDAC_AMP_EN_BIT 3
`define SDAC_BASE_DIV 32'd125
`define SDAC_RATE_MAX 3'h6
`define SDAC_RESULT_BITS 14

`endif

// ---- hdl/sdac_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module sdac_sync
    import sdac_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Asynchronous level in, synchronous level out.
    input wire logic async_in,
    output logic sync_out
);
    logic [1:0] stage_r;

    assign sync_out = stage_r[1];

    always_ff @(posedge clk) begin
        if (reset) begin
            stage_r <= 2'h0;
        end else begin
            stage_r <= {stage_r[0], async_in};
        end
    end

endmodule : sdac_sync
`default_nettype wire

// ---- hdl/sdac_top.sv ----
// Functional notes
// - The converter turns the input to reference ratio into a 14-bit value.
// - Two reference and two input signals are handled as differential pairs.
// - The result reads as high byte at 10h and low byte at 11h, reset zero.
// - Control bit 3 enables the comb filter; clear forces the result to zero.
// - Rate code n divides the converter clock by 125 times 2^n, 111 as 110.
// - Amplifier inputs follow their own three and two bit select fields.
// - The amplifier takes a two-bit chopper field and an enable flag.
// - The on flag runs the converter while control bit 3 is set; the short control ties the inputs.
`timescale 1ns/1ps
`default_nettype none

`include "sdac_regs.svh"

module sdac_top
    import sdac_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Modulator bit streams from the analog side.
    input wire logic mod_pos_bit,
    input wire logic mod_neg_bit,
    // Analog controls.
    output logic converter_on_flag,
    output logic input_short_control,
    output logic [1:0] converter_gain_field,
    output logic internal_reference_enable,
    output logic [1:0] negative_input_select,
    output logic [2:0] filter_input_select,
    output logic [2:0] positive_input_select,
    output logic [1:0] negative_reference_select,
    output logic [1:0] positive_reference_select,
    output logic [2:0] amp_noninv_select,
    output logic [1:0] amp_inv_select,
    output logic [1:0] amp_chopper_field,
    output logic amp_enable_flag,
    // Interrupt request.
    output logic converter_irq
);
    // ****************************************************************
    // Input capture and sample buffer
    // ****************************************************************
    sdac_ctl_t st_r;
    sdac_ctl_t st_nxt;
    logic pos_s;
    logic neg_s;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic fifo_pop;
    logic new_result;
    logic [12:0] rate_div;
    logic [15:0] filtered;

    sdac_sync u_sync_pos (
        .clk(clk),
        .reset(reset),
        .async_in(mod_pos_bit),
        .sync_out(pos_s)
    );

    sdac_sync u_sync_neg (
        .clk(clk),
        .reset(reset),
        .async_in(mod_neg_bit),
        .sync_out(neg_s)
    );

    // Results queue here for software reading the sample port; results arriving while it is full are lost.
    sdac_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(new_result),
        .in_ready(fifo_in_ready),
        .in_data(filtered),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ****************************************************************
    // Rate divider and result path
    // ****************************************************************
    // Codes above 110 saturate to the slowest rate.
    always_comb begin
        logic [2:0] code;
        code = st_r.conv_ctrl[2:0];
        if (code > `SDAC_RATE_MAX) begin
            code = `SDAC_RATE_MAX;
        end
        rate_div = 13'(`SDAC_BASE_DIV << code);
    end

    // The count of positive minus negative modulator bits over one output
    // period is the ratio of input to reference; it is clipped to 14 bits.
    always_comb begin
        logic [15:0] lim;
        lim = 16'((1 << (`SDAC_RESULT_BITS - 1)) - 1);
        if ($signed(st_r.accum) > $signed(lim)) begin
            filtered = lim;
        end else if ($signed(st_r.accum) < -$signed(lim)) begin
            filtered = -lim;
        end else begin
            filtered = st_r.accum;
        end
    end

    // A full queue drops the result; the registers still update.
    assign new_result = st_r.state == SDAC_DUMP;
    assign fifo_pop = reg_read && reg_addr == `SDAC_ADDR_SAMPLE;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_data = `SDAC_RST_BYTE;
        unique case (st_r.state)
            SDAC_IDLE: begin
                st_nxt.rate_cnt = '0;
                st_nxt.accum = `SDAC_RST_WORD;
                if (st_r.net_c[`SDAC_ONF_BIT]
                    && st_r.conv_ctrl[`SDAC_COMB_BIT]) begin
                    st_nxt.state = SDAC_RUN;
                end
            end
            SDAC_RUN: begin
                // Shorted inputs give zero difference in both streams.
                if (!st_r.net_c[`SDAC_SHORT_BIT]) begin
                    st_nxt.accum = st_r.accum
                        + 16'(pos_s) - 16'(neg_s);
                end
                st_nxt.rate_cnt = st_r.rate_cnt + 13'h1;
                if (st_r.rate_cnt >= rate_div - 13'h1) begin
                    st_nxt.state = SDAC_DUMP;
                end
                if (!st_r.net_c[`SDAC_ONF_BIT]
                    || !st_r.conv_ctrl[`SDAC_COMB_BIT]) begin
                    st_nxt.state = SDAC_IDLE;
                end
            end
            SDAC_DUMP: begin
                st_nxt.result = filtered;
                st_nxt.flags[`SDAC_IRQ_BIT] = 1'b1;
                st_nxt.rate_cnt = '0;
                st_nxt.accum = `SDAC_RST_WORD;
                st_nxt.state = SDAC_RUN;
            end
            default: st_nxt.state = SDAC_IDLE;
        endcase

        if (reg_write) begin
            unique case (reg_addr)
                `SDAC_ADDR_IRQ_FLAGS: begin
                    st_nxt.flags = reg_wdata;
                    // A new result in the clearing cycle still wins.
                    if (new_result) begin
                        st_nxt.flags[`SDAC_IRQ_BIT] = 1'b1;
                    end
                end
                `SDAC_ADDR_IRQ_EN: st_nxt.irq_en = reg_wdata;
                `SDAC_ADDR_CONV_CTRL: st_nxt.conv_ctrl = reg_wdata[3:0];
                `SDAC_ADDR_CHOP_CTRL:
                    st_nxt.chop = reg_wdata[`SDAC_CHOP_LSB+:2];
                `SDAC_ADDR_NET_A: st_nxt.net_a = reg_wdata;
                `SDAC_ADDR_NET_B: st_nxt.net_b = reg_wdata[5:0];
                `SDAC_ADDR_NET_C:
                    st_nxt.net_c = {reg_wdata[7], reg_wdata[3:0]};
                `SDAC_ADDR_NET_D: st_nxt.net_d = reg_wdata[3:0];
                default: ;
            endcase
        end

        // Comb filter off: the digital result reads as zero.
        if (!st_r.conv_ctrl[`SDAC_COMB_BIT]) begin
            st_nxt.result = `SDAC_RST_WORD;
        end

        if (reg_read) begin
            unique case (reg_addr)
                `SDAC_ADDR_IRQ_FLAGS: st_nxt.rd_data = st_r.flags;
                `SDAC_ADDR_IRQ_EN: st_nxt.rd_data = st_r.irq_en;
                `SDAC_ADDR_RES_HI: st_nxt.rd_data = st_r.result[15:8];
                `SDAC_ADDR_RES_LO: st_nxt.rd_data = st_r.result[7:0];
                `SDAC_ADDR_CONV_CTRL:
                    st_nxt.rd_data = {4'h0, st_r.conv_ctrl};
                `SDAC_ADDR_CHOP_CTRL:
                    st_nxt.rd_data = {4'h0, st_r.chop, 2'h0};
                `SDAC_ADDR_NET_A: st_nxt.rd_data = st_r.net_a;
                `SDAC_ADDR_NET_B: st_nxt.rd_data = {2'h0, st_r.net_b};
                `SDAC_ADDR_NET_C:
                    st_nxt.rd_data = {st_r.net_c[4], 3'h0, st_r.net_c[3:0]};
                `SDAC_ADDR_NET_D: st_nxt.rd_data = {4'h0, st_r.net_d};
                `SDAC_ADDR_SAMPLE: begin
                    // Low byte of the oldest queued result; zero when empty.
                    if (fifo_out_valid) begin
                        st_nxt.rd_data = fifo_out_data[7:0];
                    end
                end
                default: st_nxt.rd_data = `SDAC_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata = st_r.rd_data;
    assign converter_on_flag = st_r.net_c[`SDAC_ONF_BIT];
    assign input_short_control = st_r.net_c[`SDAC_SHORT_BIT];
    assign converter_gain_field = st_r.net_c[3:2];
    assign internal_reference_enable = st_r.net_c[4];
    assign negative_input_select = st_r.net_a[7:6];
    assign filter_input_select = st_r.net_a[5:3];
    assign positive_input_select = st_r.net_a[2:0];
    assign negative_reference_select = st_r.net_b[3:2];
    assign positive_reference_select = st_r.net_b[1:0];
    assign amp_inv_select = st_r.net_b[5:4];
    assign amp_noninv_select = st_r.net_d[2:0];
    assign amp_enable_flag = st_r.net_d[`SDAC_AMP_EN_BIT];
    assign amp_chopper_field = st_r.chop;
    assign converter_irq = st_r.flags[`SDAC_IRQ_BIT]
        && st_r.irq_en[`SDAC_IRQ_BIT] && st_r.irq_en[`SDAC_GIE_BIT];

    // ****************************************************************
    // Checks
    // ****************************************************************
    comb_off_zero_a: assert property (@(posedge clk) disable iff (reset)
        !st_r.conv_ctrl[`SDAC_COMB_BIT] |=> st_r.result == 16'h0000)
        else $error("result not zero with comb filter off");

    result_sets_flag_a: assert property (@(posedge clk)
        disable iff (reset)
        st_r.state == SDAC_DUMP |=> st_r.flags[`SDAC_IRQ_BIT])
        else $error("new result did not set the flag");

    irq_gating_a: assert property (@(posedge clk) disable iff (reset)
        converter_irq |-> st_r.irq_en[`SDAC_GIE_BIT])
        else $error("irq raised without global enable");

    rate_base_a: assert property (@(posedge clk) disable iff (reset)
        st_r.conv_ctrl[2:0] == 3'h0 |-> rate_div == 13'h007D)
        else $error("code 000 does not divide by 125");

    rate_top_a: assert property (@(posedge clk) disable iff (reset)
        st_r.conv_ctrl[2:0] == 3'h7 |-> rate_div == 13'h1F40)
        else $error("code 111 does not divide by 8000");

    result_range_a: assert property (@(posedge clk) disable iff (reset)
        $signed(st_r.result) <= $signed(16'h1FFF)
        && $signed(st_r.result) >= -$signed(16'h1FFF))
        else $error("result beyond 14 bits");

    short_holds_a: assert property (@(posedge clk) disable iff (reset)
        st_r.state == SDAC_RUN && st_r.net_c[`SDAC_SHORT_BIT]
        && st_nxt.state == SDAC_RUN |=> $stable(st_r.accum))
        else $error("accumulator moved with inputs shorted");

    read_hi_a: assert property (@(posedge clk) disable iff (reset)
        reg_read && reg_addr == `SDAC_ADDR_RES_HI && !reg_write
        |=> reg_rdata == $past(st_r.result[15:8]))
        else $error("high result byte read wrong");

    amp_sel_a: assert property (@(posedge clk) disable iff (reset)
        reg_write && reg_addr == `SDAC_ADDR_NET_D
        |=> amp_noninv_select == $past(reg_wdata[2:0]))
        else $error("amplifier select not taken");

    irq_raise_a: assert property (@(posedge clk) disable iff (reset)
        st_r.state == SDAC_DUMP && st_r.irq_en[`SDAC_IRQ_BIT]
        && st_r.irq_en[`SDAC_GIE_BIT]
        && !(reg_write && reg_addr == `SDAC_ADDR_IRQ_EN) |=> converter_irq)
        else $error("enabled result did not raise the request");

    flag_clear_a: assert property (@(posedge clk) disable iff (reset)
        reg_write && reg_addr == `SDAC_ADDR_IRQ_FLAGS
        && !reg_wdata[`SDAC_IRQ_BIT] && !new_result
        |=> !st_r.flags[`SDAC_IRQ_BIT])
        else $error("flag not cleared by software");

    read_lo_a: assert property (@(posedge clk) disable iff (reset)
        reg_read && reg_addr == `SDAC_ADDR_RES_LO && !reg_write
        |=> reg_rdata == $past(st_r.result[7:0]))
        else $error("low result byte read wrong");

    result_ro_a: assert property (@(posedge clk) disable iff (reset)
        reg_write && (reg_addr == `SDAC_ADDR_RES_HI
        || reg_addr == `SDAC_ADDR_RES_LO) && st_r.state != SDAC_DUMP
        && st_r.conv_ctrl[`SDAC_COMB_BIT] |=> $stable(st_r.result))
        else $error("result changed by a register write");

    idle_read_zero_a: assert property (@(posedge clk) disable iff (reset)
        !reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero without a read");

    sample_read_a: assert property (@(posedge clk) disable iff (reset)
        reg_read && reg_addr == `SDAC_ADDR_SAMPLE && fifo_out_valid
        |=> reg_rdata == $past(fifo_out_data[7:0]))
        else $error("queued result read wrong");

    off_idle_a: assert property (@(posedge clk) disable iff (reset)
        !st_r.net_c[`SDAC_ONF_BIT] && st_r.state != SDAC_DUMP
        |=> st_r.state == SDAC_IDLE)
        else $error("converter kept running while off");

    rate_mid_a: assert property (@(posedge clk) disable iff (reset)
        st_r.conv_ctrl[2:0] == 3'h3 |-> rate_div == 13'h03E8)
        else $error("code 011 does not divide by 1000");

    period_end_a: assert property (@(posedge clk) disable iff (reset)
        st_r.state == SDAC_RUN && st_r.rate_cnt == rate_div - 13'h1
        && st_r.net_c[`SDAC_ONF_BIT] && st_r.conv_ctrl[`SDAC_COMB_BIT]
        |=> st_r.state == SDAC_DUMP)
        else $error("output period did not end on time");

    dump_once_a: assert property (@(posedge clk) disable iff (reset)
        st_r.state == SDAC_DUMP |=> st_r.state == SDAC_RUN
        && st_r.rate_cnt == 13'h0 && st_r.accum == 16'h0000)
        else $error("result cycle did not restart the window");

    rate_cnt_bound_a: assert property (@(posedge clk) disable iff (reset)
        st_r.rate_cnt <= 13'h1F40)
        else $error("window counter past the slowest rate");

endmodule : sdac_top
`default_nettype wire

// ---- testbench/sdac_mod_src.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Modulator stream source standing in for the analog front end.
// ****************************************************************
module sdac_mod_src
    import sdac_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Stimulus: 0 balanced, 1 full positive, 2 full negative.
    input wire logic [1:0] mode,
    // Modulator streams.
    output logic mod_pos_bit,
    output logic mod_neg_bit
);
    logic tgl_r = 1'h0;

    // The balanced case toggles both streams together, so a stuck line
    // cannot pass for a zero input.
    always @(posedge clk) begin
        tgl_r <= ~tgl_r;
    end

    always_comb begin
        mod_pos_bit = tgl_r;
        mod_neg_bit = tgl_r;
        if (mode == 2'h1) begin
            mod_pos_bit = 1'h1;
            mod_neg_bit = 1'h0;
        end else if (mode == 2'h2) begin
            mod_pos_bit = 1'h0;
            mod_neg_bit = 1'h1;
        end
    end
endmodule : sdac_mod_src

`default_nettype wire

// ---- testbench/sdac_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "sdac_regs.svh"

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end

module sdac_top_tb
    import sdac_pkg::*;
;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'h0;
    logic reg_read = 1'h0;
    logic [7:0] reg_rdata;
    logic [1:0] mode = 2'h1;
    logic mod_pos_bit, mod_neg_bit, converter_on_flag, input_short_control;
    logic internal_reference_enable, amp_enable_flag, converter_irq;
    logic [1:0] converter_gain_field, negative_input_select, amp_inv_select;
    logic [1:0] negative_reference_select, positive_reference_select;
    logic [1:0] amp_chopper_field;
    logic [2:0] filter_input_select, positive_input_select, amp_noninv_select;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] raddr [12] = '{8'h06, 8'h07, 8'h10, 8'h11, 8'h13, 8'h15,
        8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h20};

    always #5 clk = ~clk;

    sdac_top #(.FIFO_DEPTH(16)) dut (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .mod_pos_bit(mod_pos_bit), .mod_neg_bit(mod_neg_bit),
        .converter_on_flag(converter_on_flag),
        .input_short_control(input_short_control),
        .converter_gain_field(converter_gain_field),
        .internal_reference_enable(internal_reference_enable),
        .negative_input_select(negative_input_select),
        .filter_input_select(filter_input_select),
        .positive_input_select(positive_input_select),
        .negative_reference_select(negative_reference_select),
        .positive_reference_select(positive_reference_select),
        .amp_noninv_select(amp_noninv_select),
        .amp_inv_select(amp_inv_select),
        .amp_chopper_field(amp_chopper_field),
        .amp_enable_flag(amp_enable_flag), .converter_irq(converter_irq));

    sdac_mod_src src (.clk(clk), .mode(mode), .mod_pos_bit(mod_pos_bit),
        .mod_neg_bit(mod_neg_bit));

    // ****************************************************************
    // Register port tasks.
    // ****************************************************************
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'h0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_read <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'h0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd

    task rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK($sformatf("reg %h", a), e, d)
    endtask : rchk

    task chk_res(input logic [15:0] e);
        rchk(`SDAC_ADDR_RES_HI, e[15:8]);
        rchk(`SDAC_ADDR_RES_LO, e[7:0]);
    endtask : chk_res

    // Counts edges until the request is seen low and then high again,
    // because a cleared flag may take an edge to drop.
    task wait_rise(inout int n);
        bit seen0;
        seen0 = 1'h0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (converter_irq !== 1'h1) seen0 = 1'h1;
        end while (!(seen0 && converter_irq === 1'h1) && n < 20000);
    endtask : wait_rise

    // The first rise may close a window started under old settings, so
    // only the second one is measured.
    task meas(output int p);
        int n;
        n = 0;
        wr(`SDAC_ADDR_IRQ_FLAGS, 8'h00);
        wait_rise(n);
        wr(`SDAC_ADDR_IRQ_FLAGS, 8'h00);
        n = 2;
        wait_rise(n);
        p = n;
    endtask : meas

    task set_mode(input logic [1:0] m);
        mode <= m;
        repeat (5) @(posedge clk);
    endtask : set_mode

    task conclude;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            conclude();
        end
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        int p;
        logic [7:0] d;
        repeat (12) @(posedge clk);
        reset <= 1'h0;
        foreach (raddr[i]) rchk(raddr[i], 8'h00);
        wr(`SDAC_ADDR_NET_A, 8'hB5);
        wr(`SDAC_ADDR_NET_B, 8'h1B);
        wr(`SDAC_ADDR_NET_C, 8'h8D);
        wr(`SDAC_ADDR_NET_D, 8'h0D);
        wr(`SDAC_ADDR_CHOP_CTRL, 8'hFF);
        wr(`SDAC_ADDR_CONV_CTRL, 8'hFF);
        wr(`SDAC_ADDR_RES_HI, 8'hFF);
        wr(8'h20, 8'hFF);
        rchk(`SDAC_ADDR_NET_A, 8'hB5);
        rchk(`SDAC_ADDR_NET_B, 8'h1B);
        rchk(`SDAC_ADDR_NET_C, 8'h8D);
        rchk(`SDAC_ADDR_NET_D, 8'h0D);
        rchk(`SDAC_ADDR_CHOP_CTRL, 8'h0C);
        rchk(`SDAC_ADDR_CONV_CTRL, 8'h0F);
        rchk(`SDAC_ADDR_RES_HI, 8'h00);
        rchk(8'h20, 8'h00);
        `CHK("amp inputs", 5'h15, {amp_noninv_select, amp_inv_select})
        `CHK("amp ctl", 3'h7, {amp_chopper_field, amp_enable_flag})
        `CHK("conv inputs", 8'hB5, {negative_input_select, filter_input_select,
            positive_input_select})
        `CHK("refs", 5'h1B, {internal_reference_enable,
            negative_reference_select, positive_reference_select})
        `CHK("conv ctl", 4'hD, {converter_gain_field, converter_on_flag,
            input_short_control})
        wr(`SDAC_ADDR_NET_C, 8'h02);
        wr(`SDAC_ADDR_CONV_CTRL, 8'h08);
        wr(`SDAC_ADDR_IRQ_EN, 8'h04);
        repeat (300) @(posedge clk);
        rchk(`SDAC_ADDR_IRQ_FLAGS, 8'h04);
        `CHK("masked irq", 1'h0, converter_irq)
        wr(`SDAC_ADDR_IRQ_EN, 8'h84);
        for (int c = 0; c < 8; c++) begin
            int s;
            s = (c == 7) ? 6 : c;
            wr(`SDAC_ADDR_CONV_CTRL, 8'h08 | c[7:0]);
            meas(p);
            `CHK("period", (125 << s) + 1, p)
            chk_res(16'(125 << s));
        end
        wr(`SDAC_ADDR_CONV_CTRL, 8'h08);
        set_mode(2'h2);
        meas(p);
        chk_res(16'hFF83);
        set_mode(2'h0);
        meas(p);
        chk_res(16'h0000);
        set_mode(2'h1);
        wr(`SDAC_ADDR_NET_C, 8'h03);
        meas(p);
        chk_res(16'h0000);
        wr(`SDAC_ADDR_NET_C, 8'h02);
        meas(p);
        chk_res(16'h007D);
        wr(`SDAC_ADDR_CONV_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        chk_res(16'h0000);
        // The queue holds stale results from the runs above; empty it
        // first, then overfill it so that the drop on full is exercised.
        wr(`SDAC_ADDR_NET_C, 8'h00);
        repeat (16) rd(`SDAC_ADDR_SAMPLE, d);
        rchk(`SDAC_ADDR_SAMPLE, 8'h00);
        wr(`SDAC_ADDR_CONV_CTRL, 8'h08);
        wr(`SDAC_ADDR_NET_C, 8'h02);
        repeat (2700) @(posedge clk);
        wr(`SDAC_ADDR_NET_C, 8'h00);
        repeat (16) rchk(`SDAC_ADDR_SAMPLE, 8'h7D);
        rchk(`SDAC_ADDR_SAMPLE, 8'h00);
        conclude();
    end
endmodule : sdac_top_tb

`default_nettype wire
